// ---- src/cbo_capture_port.v ----
`timescale 1ns/1ps
`include "cbo_defs.vh"
// Functional notes
// - External reset clears pointers and count, not control
// - Reset forces full low, empty high, except pin reset in bypass
// - Reset ends reads; write data may corrupt
// - Pointers restart at every write phase start
// - Edge select picks data-ready transition edge
// - Test mode entry; floating select reads high
// - Outputs released when disabled, except test
// - Buffered data follows read clock; empty flag the sample clock
// - One byte stored per clock under write
// - One byte read per read clock rise
// - Write wins over read, always
// - Auto-stop halts writes once full
// - Test mode uses auto-stop as edge select
// - Eight bit output, bypass or buffered rate
// - Idle data and strobe opposite edge select
// - Strobe toggles in bypass, only reads buffered
// - Sampling marker follows the sample clock
// - Storage holds 1024 bytes
// - Size code: bypass, 256, 512, 1024
// - Empty flag on clock, cleared by writes
// - Full flag at size; writes wrap without stop
// - Bypass ignores buffer controls, flags low
module cbo_capture_port #(
    parameter DEPTH = `CBO_DEPTH,
    parameter AW    = 10
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        device_reset,
    input  wire        write_enable,
    input  wire        read_enable,
    input  wire        read_clock,
    input  wire [7:0]  sample_data,
    output reg  [7:0]  data_out,
    output wire        data_out_oe_n,
    output reg         data_ready_strobe,
    output wire        data_ready_oe_n,
    output reg         buffer_empty_flag,
    output reg         buffer_full_flag,
    output reg         sampling_marker
);

    localparam CW = AW + 1;

    // Control register
    reg  [5:0]    ctrl_q;
    // Synchroniser stages: bit0 reset, 1 write, 2 read, 3 read clock
    reg  [3:0]    sync1_q;
    reg  [3:0]    sync2_q;
    reg  [3:0]    sync3_q;
    reg  [3:0]    filt_q;
    reg  [3:0]    filt_d;
    reg  [AW-1:0] wr_ptr_q;
    reg  [AW-1:0] rd_ptr_q;
    reg  [CW-1:0] count_q;
    reg  [7:0]    mem [0:DEPTH-1];

    wire [1:0]    size_sel;
    wire          bypass;
    wire          test_mode;
    wire          edge_sel;
    wire          auto_stop;
    wire [CW-1:0] size;
    wire          rst_f;
    wire          wen_f;
    wire          ren_f;
    wire          rclk_rise;
    wire          rclk_fall;
    wire          wen_rise;
    wire          full;
    wire          do_write;
    wire          do_read;
    wire          apb_wr;
    wire          apb_rd;
    wire          addr_ok;

    function [CW-1:0] size_of;
        input [1:0] sel;
        begin
            case (sel)
                `CBO_SIZE_256:  size_of = 11'h100;
                `CBO_SIZE_512:  size_of = 11'h200;
                `CBO_SIZE_1024: size_of = 11'h400;
                default:        size_of = 11'h000;
            endcase
        end
    endfunction

    function [AW-1:0] ptr_next;
        input [AW-1:0] p;
        input [CW-1:0] lim;
        begin
            if ({1'b0, p} == lim - 11'h001) begin
                ptr_next = {AW{1'b0}};
            end else begin
                ptr_next = p + {{(AW-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    assign size_sel  = {ctrl_q[`CBO_CTRL_SIZE_HI], ctrl_q[`CBO_CTRL_SIZE_LO]};
    assign bypass    = (size_sel == `CBO_SIZE_BYPASS);
    assign size      = size_of(size_sel);
    assign test_mode = ctrl_q[`CBO_CTRL_TEST];
    // In test mode the auto-stop bit turns into the edge select
    assign edge_sel  = test_mode ? ctrl_q[`CBO_CTRL_AUTOSTOP]
                                 : ctrl_q[`CBO_CTRL_EDGE];
    assign auto_stop = ctrl_q[`CBO_CTRL_AUTOSTOP] & ~test_mode;

    assign rst_f     = filt_q[0];
    assign wen_f     = filt_q[1];
    assign ren_f     = filt_q[2];
    assign rclk_rise = filt_d[3] & ~filt_q[3];
    assign rclk_fall = ~filt_d[3] & filt_q[3];
    assign wen_rise  = filt_d[1] & ~filt_q[1];

    assign full      = (count_q == size);
    // Auto-stop only matters while writing
    assign do_write  = ~bypass & ~rst_f & filt_d[1]
                     & ~(full & auto_stop & ~wen_rise);
    // Write enable always wins, so reads never overlap writes
    assign do_read   = ~bypass & ~rst_f & ~filt_d[1] & ren_f & rclk_rise
                     & (count_q != {CW{1'b0}});

    assign apb_wr    = psel & penable & pwrite;
    assign apb_rd    = psel & ~pwrite;
    assign addr_ok   = (paddr == `CBO_CTRL_ADDR) | (paddr == `CBO_STAT_ADDR);
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~addr_ok;

    // Outputs stay driven in test mode regardless of enable
    assign data_out_oe_n   = ~(ctrl_q[`CBO_CTRL_OE] | test_mode);
    assign data_ready_oe_n = ~(ctrl_q[`CBO_CTRL_OE] | test_mode);

    // A change counts once the second and third stages agree
    always @* begin
        filt_d = filt_q;
        if (sync2_q[0] == sync3_q[0]) filt_d[0] = sync3_q[0];
        if (sync2_q[1] == sync3_q[1]) filt_d[1] = sync3_q[1];
        if (sync2_q[2] == sync3_q[2]) filt_d[2] = sync3_q[2];
        if (sync2_q[3] == sync3_q[3]) filt_d[3] = sync3_q[3];
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
            filt_q  <= 4'h0;
        end else if (clk_en) begin
            sync1_q <= {read_clock, read_enable, write_enable, device_reset};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q  <= filt_d;
        end
    end

    // APB slave: zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CBO_CTRL_RESET;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (apb_wr && paddr == `CBO_CTRL_ADDR) begin
                ctrl_q <= pwdata[5:0];
            end
            if (apb_rd && !penable) begin
                case (paddr)
                    `CBO_CTRL_ADDR: prdata <= {26'h0, ctrl_q};
                    `CBO_STAT_ADDR: prdata <= {{(16-CW){1'b0}}, count_q,
                                               13'h0, test_mode,
                                               buffer_full_flag,
                                               buffer_empty_flag};
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Storage has no reset; a reset mid-write may leave stale bytes
    always @(posedge pclk) begin
        if (clk_en && do_write) begin
            mem[wen_rise ? {AW{1'b0}} : wr_ptr_q] <= sample_data;
        end
    end

    // Pointers and flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q          <= {AW{1'b0}};
            rd_ptr_q          <= {AW{1'b0}};
            count_q           <= {CW{1'b0}};
            buffer_empty_flag <= 1'b1;
            buffer_full_flag  <= 1'b0;
        end else if (clk_en) begin
            if (rst_f) begin
                wr_ptr_q          <= {AW{1'b0}};
                rd_ptr_q          <= {AW{1'b0}};
                count_q           <= {CW{1'b0}};
                buffer_empty_flag <= ~bypass;
                buffer_full_flag  <= 1'b0;
            end else if (bypass) begin
                buffer_empty_flag <= 1'b0;
                buffer_full_flag  <= 1'b0;
            end else begin
                if (do_write && wen_rise) begin
                    // Each write phase starts from cleared pointers
                    wr_ptr_q   <= ptr_next({AW{1'b0}}, size);
                    rd_ptr_q   <= {AW{1'b0}};
                    count_q    <= 11'h001;
                end else if (do_write) begin
                    wr_ptr_q <= ptr_next(wr_ptr_q, size);
                    if (full) begin
                        // Overwrite: the oldest byte goes with it
                        rd_ptr_q <= ptr_next(rd_ptr_q, size);
                    end else begin
                        count_q <= count_q + 11'h001;
                    end
                end else if (do_read) begin
                    rd_ptr_q <= ptr_next(rd_ptr_q, size);
                    count_q  <= count_q - 11'h001;
                end
                buffer_empty_flag <= (count_q == {CW{1'b0}}) & ~do_write;
                buffer_full_flag  <= full & ~do_read;
            end
        end
    end

    // Output port
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out          <= 8'h00;
            data_ready_strobe <= 1'b0;
            sampling_marker   <= 1'b0;
        end else if (clk_en) begin
            sampling_marker <= ~sampling_marker;
            if (bypass) begin
                // Strobe runs at half the clock; data moves on its active edge
                data_ready_strobe <= ~data_ready_strobe;
                if (~data_ready_strobe == edge_sel) begin
                    data_out <= sample_data;
                end
            end else if (do_read) begin
                data_out          <= mem[rd_ptr_q];
                data_ready_strobe <= edge_sel;
            end else if (rclk_fall || rst_f || filt_d[1]) begin
                data_ready_strobe <= ~edge_sel;
                if (rst_f || filt_d[1] || !ren_f
                    || count_q == {CW{1'b0}}) begin
                    data_out <= {8{~edge_sel}};
                end
            end else if (!ren_f) begin
                data_ready_strobe <= ~edge_sel;
                data_out          <= {8{~edge_sel}};
            end
        end
    end

endmodule

// ---- src/cbo_defs.vh ----
`ifndef CBO_DEFS_VH
`define CBO_DEFS_VH

// APB register byte offsets
`define CBO_CTRL_ADDR      8'h00
`define CBO_STAT_ADDR      8'h04

// Control register fields
`define CBO_CTRL_SIZE_LO   0
`define CBO_CTRL_SIZE_HI   1
`define CBO_CTRL_AUTOSTOP  2
`define CBO_CTRL_EDGE      3
`define CBO_CTRL_TEST      4
`define CBO_CTRL_OE        5
`define CBO_CTRL_RESET     6'h08

// Status register fields
`define CBO_STAT_EMPTY     0
`define CBO_STAT_FULL      1
`define CBO_STAT_TEST      2
`define CBO_STAT_CNT_LSB   16

// Buffer size codes
`define CBO_SIZE_BYPASS    2'h0
`define CBO_SIZE_256       2'h1
`define CBO_SIZE_512       2'h2
`define CBO_SIZE_1024      2'h3

// Buffer depth in bytes
`define CBO_DEPTH          1024

// Least external reset width in sample clocks
`define CBO_RST_MIN_CYC    4

`endif

// ---- tb/capture_buffer_output_port_test.sv ----
`timescale 1ns/1ps
module capture_buffer_output_port_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, run;
    logic [7:0]  paddr, sdata, dout;
    logic [31:0] pwdata, prdata, rd;
    logic        dev_rst, wen, ren, rclk, strb, ef, ff, doe_n, soe_n;
    int          n_fail, checks;
    cbo_capture_port i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .device_reset(dev_rst), .write_enable(wen),
        .read_enable(ren), .read_clock(rclk), .sample_data(sdata), .data_out(dout),
        .data_out_oe_n(doe_n), .data_ready_strobe(strb), .data_ready_oe_n(soe_n),
        .buffer_empty_flag(ef), .buffer_full_flag(ff), .sampling_marker());
    cbo_reader i_rd (.pclk(pclk), .edge_sel(1'b1), .data_out(dout),
        .data_ready_strobe(strb), .read_clock(rclk), .read_enable(ren));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) if (run) sdata <= sdata + 8'h1;
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16) begin
            n_fail++;
            close_out();
        end
    endtask
    // Pulse the pin reset, then capture with auto-stop on into the chosen size
    task automatic t_fill(input logic [1:0] code);
        int k;
        apb(1'b1, 8'h00, {24'h0, 6'h0b, code});
        dev_rst <= 1'b1;
        repeat (8) @(posedge pclk);
        check("ef_rst", ef, 1);
        dev_rst <= 1'b0;
        repeat (6) @(posedge pclk);
        wen <= 1'b1;
        run <= 1'b1;
        for (k = 0; k < 1100 && ff !== 1'b1; k++) @(posedge pclk);
        check("ff", ff, 1);
        if (k == 1100) close_out();
        repeat (20) @(posedge pclk);
        wen <= 1'b0;
        run <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b0, 8'h04, 0);
        check("count", rd[26:16], 32'd256 << (code - 1));
    endtask
    // Without auto-stop the write pointer wraps and the buffer stays full
    task automatic t_wrap;
        apb(1'b1, 8'h00, 32'h29);
        wen <= 1'b1;
        run <= 1'b1;
        repeat (300) @(posedge pclk);
        wen <= 1'b0;
        run <= 1'b0;
        repeat (10) @(posedge pclk);
        check("wrap_ff", ff, 1);
        apb(1'b0, 8'h04, 0);
        check("wrap_count", rd[26:16], 32'd256);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, dev_rst, wen, run} = '0;
        {paddr, pwdata, n_fail, checks} = '0;
        sdata = 8'h5a;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, 8'h0c, 0);
        check("slverr", err, 1);
        apb(1'b0, 8'h00, 0);
        check("ctrl", rd, 32'h08);
        apb(1'b1, 8'h00, 32'h28);
        repeat (8) @(posedge pclk);
        check("flags", {ef, ff}, 0);
        check("oe", {doe_n, soe_n}, 0);
        check("bypass", dout, 8'h5a);
        for (int c = 3; c > 0; c--) t_fill(c[1:0]);
        i_rd.burst(256);
        repeat (12) @(posedge pclk);
        check("reads", i_rd.got.size(), 256);
        for (int k = 1; k < 256; k++) begin
            check("seq", i_rd.got[k], 8'(i_rd.got[k - 1] + 8'h1));
        end
        check("ef_end", {ef, ff}, 2);
        check("idle", {strb, dout}, 0);
        t_wrap();
        apb(1'b1, 8'h00, 32'h11);
        repeat (2) @(posedge pclk);
        check("test_oe", {doe_n, soe_n}, 0);
        close_out();
    end
endmodule
bind cbo_capture_port cbo_monitor i_mon (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .device_reset(device_reset), .write_enable(write_enable), .data_out_oe_n(data_out_oe_n),
    .data_ready_oe_n(data_ready_oe_n), .data_ready_strobe(data_ready_strobe),
    .buffer_empty_flag(buffer_empty_flag), .buffer_full_flag(buffer_full_flag),
    .sampling_marker(sampling_marker));

// ---- tb/cbo_monitor.sv ----
`timescale 1ns/1ps
`include "cbo_defs.vh"
module cbo_monitor (
    input logic        pclk,
    input logic        presetn,
    input logic        clk_en,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic        device_reset,
    input logic        write_enable,
    input logic        data_out_oe_n,
    input logic        data_ready_oe_n,
    input logic        data_ready_strobe,
    input logic        buffer_empty_flag,
    input logic        buffer_full_flag,
    input logic        sampling_marker
);
    logic [7:0] ctrl_q;
    logic       byp;
    logic       edge_v;
    assign byp = ctrl_q[1:0] == 2'h0;
    assign edge_v = ctrl_q[4] ? ctrl_q[2] : ctrl_q[3];
    // Shadow of the control word, so modes can be judged from the pins alone
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 8'h08;
        end else if (psel && penable && pwrite && paddr == `CBO_CTRL_ADDR) begin
            ctrl_q <= pwdata[7:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_reset_flags: assert property (
        $rose(presetn) |-> buffer_empty_flag && !buffer_full_flag)
        else $error("flags wrong after reset");
    a_pin_reset: assert property (
        (device_reset && !byp)[*8] |-> buffer_empty_flag && !buffer_full_flag)
        else $error("pin reset did not clear buffer");
    a_bypass_flags: assert property (
        byp && $past(byp, 3) && $past(presetn, 3) |-> !buffer_empty_flag && !buffer_full_flag)
        else $error("flags not low in bypass");
    a_oe_off: assert property (
        !ctrl_q[4] && !ctrl_q[5] |-> data_out_oe_n && data_ready_oe_n)
        else $error("outputs driven while disabled");
    a_test_drive: assert property (
        ctrl_q[4] |-> !data_out_oe_n && !data_ready_oe_n)
        else $error("outputs released in test mode");
    a_byp_toggle: assert property (
        byp && $past(byp, 2) && clk_en && $past(clk_en) && $past(presetn, 2) && !device_reset
        |-> data_ready_strobe != $past(data_ready_strobe))
        else $error("strobe stalled in bypass");
    a_marker_run: assert property (
        clk_en |=> sampling_marker != $past(sampling_marker))
        else $error("sampling marker stalled");
    a_flag_excl: assert property (
        !(buffer_empty_flag && buffer_full_flag))
        else $error("empty and full together");
    a_write_fill: assert property (
        (write_enable && !byp && !device_reset)[*8] |-> ##3 !buffer_empty_flag)
        else $error("empty stayed high while writing");
    a_write_idle: assert property (
        (write_enable && !byp)[*8] |-> data_ready_strobe == !edge_v)
        else $error("strobe active during write");
endmodule

// ---- tb/cbo_reader.sv ----
`timescale 1ns/1ps
module cbo_reader (
    input  logic       pclk,
    input  logic       edge_sel,
    input  logic [7:0] data_out,
    input  logic       data_ready_strobe,
    output logic       read_clock,
    output logic       read_enable
);
    logic [7:0] got[$];
    logic       s_q = 1'b0;
    logic       pend = 1'b0;
    initial begin
        read_clock = 1'b0;
        read_enable = 1'b0;
    end
    // Clock stands still between bursts; offset keeps it off the sample edges
    task automatic burst(input int n);
        got.delete();
        #1 read_enable = 1'b1;
        repeat (n) begin
            #16 read_clock = 1'b1;
            #16 read_clock = 1'b0;
        end
        #32 read_enable = 1'b0;
    endtask
    // Take data a cycle after the launching strobe edge, once it has settled
    always @(posedge pclk) begin
        if (pend) got.push_back(data_out);
        pend <= s_q !== edge_sel && data_ready_strobe === edge_sel;
        s_q <= data_ready_strobe;
    end
endmodule
